// ---- include/cfs_pkg.sv ----
// constants and types for the converter fault sequencer
// Notes on behaviour
// [R1] ignore enable until input above rising lockout
// [R2] running input low: fault, stop switching
// [R3] short input-low dips filtered by qualify time
// [R4] after input-low fault wait, restart if enabled
// [R5] input high: fault, stop switching at once
// [R6] after input-high wait recovery, restart if enabled
// [R7] fast input-high flag halts switching immediately
// [R8] unqualified input-high: resume without restart; only the fast flag does, input-high lockout while switching goes to CFS_OFF
// [R9] persistent input-high qualifies regardless of switching
// [R10] output low while switching: fault, stop
// [R11] output-low fault: hold-off, init, turn-on delays
// [R12] overtemperature: fault, stop, hold off
// [R13] overtemp recovery waits cool, then delays
// [R14] output high while switching latches fault
// [R15] output-high latch cleared only by disable
// [R16] light load gates switching on and off
// [R17] enable low disables, high or float enables
// [R18] fault pin active on fault, disable, startup
// [R19] every restart reruns full soft start
// [R20] synchronise flags, count qualify times
// [R21] latch dominates; restart after all faults except output-low clear
package cfs_pkg;
  localparam real CFS_CLK_NS        = 4.0;
  localparam real CFS_IN_LOW_US     = 10.0;  // input_low_qualify_time
  localparam real CFS_IN_HIGH_US    = 10.0;  // input_high_qualify_time
  localparam real CFS_HOLDOFF_US    = 1000.0;
  localparam real CFS_INIT_US       = 100.0;
  localparam real CFS_TURN_ON_US    = 100.0;
  localparam real CFS_SOFT_START_US = 200.0;
  localparam int CFS_IN_LOW_CYC  = int'(CFS_IN_LOW_US * 1000.0 / CFS_CLK_NS);
  localparam int CFS_IN_HIGH_CYC = int'(CFS_IN_HIGH_US * 1000.0 / CFS_CLK_NS);
  localparam int CFS_HOLDOFF_CYC = int'(CFS_HOLDOFF_US * 1000.0 / CFS_CLK_NS);
  localparam int CFS_INIT_CYC    = int'(CFS_INIT_US * 1000.0 / CFS_CLK_NS);
  localparam int CFS_TURN_ON_CYC = int'(CFS_TURN_ON_US * 1000.0 / CFS_CLK_NS);
  localparam int CFS_SOFT_CYC    = int'(CFS_SOFT_START_US * 1000.0 / CFS_CLK_NS);
  localparam int CFS_CNT_W   = 24;
  localparam int CFS_FLAGS   = 7;
  // flag bit positions in the synchronised vector
  localparam int CFS_F_EN    = 0;
  localparam int CFS_F_INOK  = 1;  // input above rising lockout
  localparam int CFS_F_INLOW = 2;  // input below falling threshold
  localparam int CFS_F_INHI  = 3;
  localparam int CFS_F_OUTLO = 4;
  localparam int CFS_F_OUTHI = 5;
  localparam int CFS_F_HOT   = 6;
  localparam logic [CFS_FLAGS-1:0] CFS_SYNC_RST = 7'h00;

  typedef enum logic [2:0] {
    CFS_OFF     = 3'b000,
    CFS_INIT    = 3'b001,
    CFS_TURN_ON = 3'b010,
    CFS_SOFT    = 3'b011,
    CFS_RUN     = 3'b100,
    CFS_HOLDOFF = 3'b101,
    CFS_WAIT    = 3'b110,
    CFS_LATCHED = 3'b111
  } cfs_state_t;
endpackage

// ---- design/cfs_sync.sv ----
// two-flop synchroniser for a vector of pin and comparator flags
`timescale 1ns/100ps
module cfs_sync #(
  parameter int W = 7
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cfs_sync_t;
  cfs_sync_t st_reg;
  cfs_sync_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next.meta   = async_in;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;
endmodule // cfs_sync

// ---- design/cfs_sequencer.sv ----
// converter fault sequencer: fault qualify, restart timing, burst gating
`timescale 1ns/100ps
module cfs_sequencer
  import cfs_pkg::*;
#(
  parameter int IN_LOW_CYC  = CFS_IN_LOW_CYC,
  parameter int IN_HIGH_CYC = CFS_IN_HIGH_CYC,
  parameter int HOLDOFF_CYC = CFS_HOLDOFF_CYC,
  parameter int INIT_CYC    = CFS_INIT_CYC,
  parameter int TURN_ON_CYC = CFS_TURN_ON_CYC,
  parameter int SOFT_CYC    = CFS_SOFT_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic primary_enable_pin_in,
  input  wire logic input_low_lockout_ok_in,
  input  wire logic input_low_lockout_in,
  input  wire logic input_high_lockout_in,
  input  wire logic fast_input_high_in,
  input  wire logic output_low_protection_in,
  input  wire logic output_high_protection_in,
  input  wire logic over_temp_in,
  input  wire logic light_load_in,
  output logic      switch_enable_out,
  output logic      soft_start_out,
  output logic      fault_indicator_pin_out,
  output logic      fault_latched_out,
  output cfs_pkg::cfs_state_t state_out
);
  import cfs_pkg::*;

  typedef struct packed {
    cfs_state_t           state;
    logic [CFS_CNT_W-1:0] timer;
    logic [CFS_CNT_W-1:0] low_cnt;
    logic [CFS_CNT_W-1:0] high_cnt;
    logic                 burst_off;
    logic                 sw;
    logic                 ss;
    logic                 flt;
    logic                 latch;
  } cfs_seq_t;

  cfs_seq_t st_reg;
  cfs_seq_t st_next;
  logic [CFS_FLAGS-1:0] raw_flags;
  logic [CFS_FLAGS-1:0] flags;

  // pins and comparator flags cross into the clock domain first
  assign raw_flags = {over_temp_in, output_high_protection_in,
                      output_low_protection_in, input_high_lockout_in,
                      input_low_lockout_in, input_low_lockout_ok_in,
                      primary_enable_pin_in};

  cfs_sync #(
    .W (CFS_FLAGS)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in (raw_flags),
    .sync_out (flags)
  ); // [R20]

  logic [1:0] aux_sync;
  cfs_sync #(
    .W (2)
  ) u_sync_aux (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in ({fast_input_high_in, light_load_in}),
    .sync_out (aux_sync)
  );

  logic en;
  logic in_ok;
  logic in_low;
  logic in_high;
  logic out_low;
  logic out_high;
  logic hot;
  logic fast_high;
  logic light;
  logic low_qual;
  logic high_qual;
  logic all_clear;

  always_comb begin
    en        = flags[CFS_F_EN];
    in_ok     = flags[CFS_F_INOK];
    in_low    = flags[CFS_F_INLOW];
    in_high   = flags[CFS_F_INHI];
    out_low   = flags[CFS_F_OUTLO];
    out_high  = flags[CFS_F_OUTHI];
    hot       = flags[CFS_F_HOT];
    fast_high = aux_sync[1];
    light     = aux_sync[0];
  end

  // qualify times as counters; short dips never reach the limit
  assign low_qual  = (st_reg.low_cnt >= CFS_CNT_W'(IN_LOW_CYC - 1))
                     && in_low; // [R3]
  assign high_qual = (st_reg.high_cnt >= CFS_CNT_W'(IN_HIGH_CYC - 1))
                     && in_high; // [R9]
  // restart needs input ok and no input-high, heat or output-high; output-low is not checked
  assign all_clear = in_ok && !in_high && !hot && !out_high; // [R21]

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    // qualification counters run in every state
    st_next.low_cnt  = in_low ? st_reg.low_cnt + 1'b1 : '0; // [R20]
    st_next.high_cnt = in_high ? st_reg.high_cnt + 1'b1 : '0; // [R9]
    if (low_qual) begin
      st_next.low_cnt = st_reg.low_cnt;
    end
    if (high_qual) begin
      st_next.high_cnt = st_reg.high_cnt;
    end
    // burst: while the load is too light, gate switching on alternate cycles
    st_next.burst_off = light && !st_reg.burst_off; // [R16]
    if (st_reg.timer != '0) begin
      st_next.timer = st_reg.timer - 1'b1;
    end

    unique case (st_reg.state)
      CFS_OFF: begin
        // enable ignored until input clears the rising lockout
        if (en && all_clear) begin // [R1] [R4] [R6] [R17]
          st_next.state = CFS_INIT;
          st_next.timer = CFS_CNT_W'(INIT_CYC);
        end
      end
      CFS_INIT: begin
        if (st_reg.timer == '0) begin
          st_next.state = CFS_TURN_ON;
          st_next.timer = CFS_CNT_W'(TURN_ON_CYC);
        end
      end
      CFS_TURN_ON: begin
        if (st_reg.timer == '0) begin
          st_next.state = CFS_SOFT; // [R19]
          st_next.timer = CFS_CNT_W'(SOFT_CYC);
        end
      end
      CFS_SOFT: begin
        if (st_reg.timer == '0) begin
          st_next.state = CFS_RUN;
        end
      end
      CFS_RUN: begin
      end
      CFS_HOLDOFF: begin
        // timed hold-off after output-low or overtemperature
        if (st_reg.timer == '0) begin // [R11] [R12]
          st_next.state = CFS_WAIT;
        end
      end
      CFS_WAIT: begin
        // wait for input, heat and output-high faults to clear, then full delays again
        if (all_clear && en) begin // [R13] [R11]
          st_next.state = CFS_INIT;
          st_next.timer = CFS_CNT_W'(INIT_CYC);
        end else if (!en) begin
          st_next.state = CFS_OFF;
        end
      end
      CFS_LATCHED: begin
      end
    endcase

    // fault detection while switching; priority is latch, then others
    if (st_reg.state inside {CFS_SOFT, CFS_RUN}) begin
      if (out_high && st_reg.sw) begin
        st_next.state = CFS_LATCHED; // [R14]
        st_next.latch = 1'b1;
      end else if (out_low && st_reg.sw) begin
        st_next.state = CFS_HOLDOFF; // [R10]
        st_next.timer = CFS_CNT_W'(HOLDOFF_CYC);
      end else if (hot) begin
        st_next.state = CFS_HOLDOFF; // [R12]
        st_next.timer = CFS_CNT_W'(HOLDOFF_CYC);
      end else if (low_qual || in_high) begin
        st_next.state = CFS_OFF; // [R2] [R5]
      end
    end
    // start-up aborted by a qualified input fault or by heat; heat still
    // earns the full hold-off so a quick cool-down cannot skip it
    if (st_reg.state inside {CFS_INIT, CFS_TURN_ON}) begin
      if (hot) begin
        st_next.state = CFS_HOLDOFF; // [R12]
        st_next.timer = CFS_CNT_W'(HOLDOFF_CYC);
      end else if (low_qual || high_qual) begin
        st_next.state = CFS_OFF; // [R9]
      end
    end
    // latch clears only by disable; power removal is the reset
    if (st_reg.latch) begin
      st_next.state = CFS_LATCHED; // [R21]
      if (!en) begin
        st_next.latch = 1'b0; // [R15]
        st_next.state = CFS_OFF;
      end
    end else if (!en && st_reg.state != CFS_LATCHED &&
                 st_next.state != CFS_LATCHED) begin
      st_next.state = CFS_OFF; // [R17]
    end

    // outputs registered from next state; the fast controller flag only
    // gates switching and never moves the state, so a brief event
    // resumes with no restart
    st_next.sw  = (st_next.state inside {CFS_SOFT, CFS_RUN}) &&
                  !fast_high && !st_next.burst_off; // [R5] [R7] [R8] [R16]
    st_next.ss  = (st_next.state == CFS_SOFT);
    // fault pin: inactive only when enabled and running cleanly
    st_next.flt = !(st_next.state inside {CFS_SOFT, CFS_RUN}) ||
                  (st_next.state == CFS_SOFT &&
                   st_reg.state != CFS_SOFT); // [R18]
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg       <= '0;
      st_reg.state <= CFS_OFF;
      st_reg.flt   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign switch_enable_out       = st_reg.sw;
  assign soft_start_out          = st_reg.ss;
  assign fault_indicator_pin_out = st_reg.flt;
  assign fault_latched_out       = st_reg.latch;
  assign state_out               = st_reg.state;
endmodule // cfs_sequencer

// ---- tb/cfs_checker.sv ----
// port-level assertions for the converter fault sequencer
`timescale 1ns/100ps
module cfs_checker
  import cfs_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       primary_enable_pin_in,
  input wire logic       input_low_lockout_ok_in,
  input wire logic       input_high_lockout_in,
  input wire logic       fast_input_high_in,
  input wire logic       switch_enable_out,
  input wire logic       soft_start_out,
  input wire logic       fault_indicator_pin_out,
  input wire logic       fault_latched_out,
  input wire cfs_state_t state_out
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // enable held long enough to pass the synchroniser
  sequence s_latch_en;
    (fault_latched_out && primary_enable_pin_in)[*4];
  endsequence
  sequence s_holdoff;
    (state_out == CFS_HOLDOFF)[*8];
  endsequence
  property p_latch_off;
    fault_latched_out |-> !switch_enable_out;
  endproperty
  property p_latch_keep;
    s_latch_en |=> fault_latched_out;
  endproperty
  property p_idle_off;
    state_out inside {CFS_OFF, CFS_INIT, CFS_TURN_ON, CFS_HOLDOFF,
      CFS_WAIT, CFS_LATCHED} |-> !switch_enable_out;
  endproperty
  property p_fault_pin;
    state_out inside {CFS_OFF, CFS_HOLDOFF, CFS_WAIT, CFS_LATCHED}
      |-> fault_indicator_pin_out;
  endproperty
  property p_run_quiet;
    state_out == CFS_RUN |-> !fault_indicator_pin_out;
  endproperty
  property p_soft_flag;
    soft_start_out |-> state_out == CFS_SOFT;
  endproperty
  property p_run_via_soft;
    $rose(state_out == CFS_RUN) |-> $past(state_out) == CFS_SOFT;
  endproperty
  property p_holdoff;
    $rose(state_out == CFS_HOLDOFF) |-> s_holdoff;
  endproperty
  property p_lockout;
    (state_out == CFS_OFF && !input_low_lockout_ok_in)[*4]
      |=> state_out == CFS_OFF;
  endproperty
  property p_in_high;
    input_high_lockout_in[*5] |-> !switch_enable_out;
  endproperty
  property p_fast;
    fast_input_high_in[*5] |-> !switch_enable_out;
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("switching while latched");
  a_latch_keep: assert property (p_latch_keep)
    else $error("latch cleared while enabled");
  a_idle_off: assert property (p_idle_off)
    else $error("switching in a stopped state");
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin idle while stopped");
  a_run_quiet: assert property (p_run_quiet)
    else $error("fault pin active while running");
  a_soft_flag: assert property (p_soft_flag)
    else $error("soft start flag outside soft start");
  a_run_via_soft: assert property (p_run_via_soft)
    else $error("run entered without soft start");
  a_holdoff: assert property (p_holdoff)
    else $error("hold-off cut short");
  a_lockout: assert property (p_lockout)
    else $error("start while input locked out");
  a_in_high: assert property (p_in_high)
    else $error("switching with input high");
  a_fast: assert property (p_fast)
    else $error("switching with fast input high");
endmodule // cfs_checker

// ---- tb/cfs_host_model.sv ----
// host side: pulls the enable pin low or releases it
`timescale 1ns/100ps
module cfs_host_model (
  input  wire logic hold_low_in,
  output logic      primary_enable_pin_out
);
  // released pin is driven high and enables
  assign primary_enable_pin_out = hold_low_in ? 1'b0 : 1'b1;
endmodule // cfs_host_model

// ---- tb/cfs_sequencer_tb_top.sv ----
// self-checking bench for the converter fault sequencer
`timescale 1ns/100ps
module cfs_sequencer_tb_top;
  import cfs_pkg::*;
  logic       clk_in = 0, rst_b_in = 0, hold_low = 1, ok = 0, ld = 0;
  logic [3:0] flt = 4'h0;  // input low, input high, output low, hot
  logic       hi_out = 0, fast = 0, en, sw, ss, ft, lat, a;
  cfs_state_t st;
  int         n_errors = 0, samples_checked = 0;
  always #2 clk_in = ~clk_in;
  cfs_host_model host (.hold_low_in(hold_low), .primary_enable_pin_out(en));
  // short counts keep the run brief; input-high qualify keeps its default
  cfs_sequencer #(.IN_LOW_CYC(8), .HOLDOFF_CYC(20),
    .INIT_CYC(6), .TURN_ON_CYC(6), .SOFT_CYC(10)) uut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .primary_enable_pin_in(en),
    .input_low_lockout_ok_in(ok), .input_low_lockout_in(flt[0]),
    .input_high_lockout_in(flt[1]), .fast_input_high_in(fast),
    .output_low_protection_in(flt[2]),
    .output_high_protection_in(hi_out), .over_temp_in(flt[3]),
    .light_load_in(ld), .switch_enable_out(sw), .soft_start_out(ss),
    .fault_indicator_pin_out(ft), .fault_latched_out(lat), .state_out(st));
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_st(cfs_state_t s);
    for (int i = 0; i < 300 && st !== s; i++) tick(1);
    if (st !== s) begin
      chk("state", st, s);
      wrap_up();
    end
  endtask
  // fault table: stopped state, and state part way through the hold;
  // output-low restarts without waiting, heat waits until it cools
  cfs_state_t stop_st [4] = '{CFS_OFF, CFS_OFF, CFS_HOLDOFF, CFS_HOLDOFF};
  cfs_state_t hold_st [4] = '{CFS_OFF, CFS_OFF, CFS_INIT, CFS_WAIT};
  initial begin
    tick(2);
    chk("reset", {ft, sw, lat, st}, {3'b100, CFS_OFF});
    rst_b_in = 1;
    hold_low = 0;
    tick(20);
    chk("locked", st, CFS_OFF);
    ok = 1;
    wait_st(CFS_SOFT);
    chk("soft", {sw, ss}, 2'b11);
    wait_st(CFS_RUN);
    chk("run", {sw, ss, ft}, 3'b100);
    ld = 1;
    tick(4);
    a = sw;
    tick(1);
    chk("burst", sw, !a);
    ld = 0;
    fast = 1;
    tick(4);
    chk("fast", sw, 0);
    fast = 0;
    tick(5);
    chk("resume", {st, sw}, {CFS_RUN, 1'b1});
    flt[0] = 1;
    tick(4);
    flt[0] = 0;
    tick(6);
    chk("dip", st, CFS_RUN);
    for (int k = 0; k < 4; k++) begin
      flt[k] = 1;
      ok = (k != 0);
      wait_st(stop_st[k]);
      chk("stop", {ft, sw}, 2'b10);
      tick(25);
      chk("hold", st, hold_st[k]);
      flt[k] = 0;
      ok = 1;
      wait_st(CFS_RUN);
      chk("restart", {sw, ft}, 2'b10);
    end
    hi_out = 1;
    wait_st(CFS_LATCHED);
    hi_out = 0;
    tick(40);
    chk("latch", {lat, sw, st}, {2'b10, CFS_LATCHED});
    hold_low = 1;
    wait_st(CFS_OFF);
    chk("unlatch", {lat, ft}, 2'b01);
    hold_low = 0;
    wait_st(CFS_RUN);
    chk("again", sw, 1);
    wrap_up();
  end
endmodule // cfs_sequencer_tb_top
bind cfs_sequencer cfs_checker chk_i (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .primary_enable_pin_in(primary_enable_pin_in),
  .input_low_lockout_ok_in(input_low_lockout_ok_in),
  .input_high_lockout_in(input_high_lockout_in),
  .fast_input_high_in(fast_input_high_in),
  .switch_enable_out(switch_enable_out), .soft_start_out(soft_start_out),
  .fault_indicator_pin_out(fault_indicator_pin_out),
  .fault_latched_out(fault_latched_out), .state_out(state_out));
